// >>> core/sesq_top.sv
// Erase sequencer of the serial programming port: decodes the serial
// instructions, holds the pointer and control locations, runs the
// self-timed bulk erase and reports the externally timed row erase.
// Assumes the programmer drives the serial clock and data lines.
//
// How it works
// - Erase armed by option write to 3C0004h
// - 80h chip, 81h EEPROM, 83h boot block
// - 88h..8Bh erase code blocks one to four
// - Bulk erase clears protection of erased blocks
// - Self-timed erase from 4th fall after NOP
// - Only bulk erase clears protection bits
// - Other configuration bits stay untouched by erase
// - One 64-byte row per panel, same offset
// - Row erase enabled by 40h at 3C0006h
// - Row erase held by 4th NOP pulse high
// - Row erase ends when serial clock falls
// - Instruction is 4-bit command plus 16-bit operand
// - Bits latched on falling edges, LSB first
// - Decode core, write, write-increment, write-start commands
// - Pointer is upper, high and low bytes
`timescale 1ns/1ps
module sesq_top
  import sesq_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DFLT
) (
  // System clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Serial programming link
  input  wire logic        serial_clk_in,
  input  wire logic        serial_prog_data_in,
  output logic             serial_prog_data_out,
  output logic             serial_prog_data_oe_out,
  // Protection set requests from configuration programming
  input  wire logic [5:0]  protect_set_in,
  // Erase status
  output logic             erase_busy_out,
  output logic [5:0]       erase_target_out,
  output logic [5:0]       code_protect_out,
  output logic             row_erase_active_out,
  output logic [6:0]       row_offset_out,
  // Register and pointer views
  output logic [7:0]       panel_write_control_out,
  output logic [7:0]       memory_control_reg_out,
  output logic [21:0]      table_address_pointer_out
);
  import sesq_pkg::*;

  sesq_link_if lnk ();

  logic        tgl_s1, tgl_s2, tgl_s3;
  logic        req_s1, req_s2, req_s3;
  logic        hold_s1, hold_s2;
  logic        instr_new;
  logic        erase_start;
  logic [3:0]  cmd;
  logic [7:0]  op_hi;
  logic [7:0]  op_lo;
  logic        is_tw;
  logic [7:0]  wreg;
  logic [7:0]  erase_option_control;
  logic [7:0]  panel_write_control;
  logic [7:0]  memory_control_reg;
  logic [5:0]  pointer_upper_byte;
  logic [7:0]  pointer_high_byte;
  logic [7:0]  pointer_low_byte;
  logic [21:0] table_address_pointer;
  logic        row_mode;
  logic        timer_busy;
  logic        timer_done;
  logic        erase_ack_tgl;
  logic        erase_armed;
  logic [5:0]  erase_target;
  logic [5:0]  code_protect;

  // Serial-clock front end; its toggles and row hold are resynchronised here, the instruction word is read directly
  sesq_serial_link u_link (
    .link_clk_in (serial_clk_in),
    .rst_in      (rst_in),
    .data_in     (serial_prog_data_in),
    .lnk         (lnk.link)
  );

  // Self-timed bulk erase counter
  sesq_erase_timer #(
    .CYCLES (ERASE_CYCLES)
  ) u_timer (
    .clk_in   (sys_clk_in),
    .rst_in   (rst_in),
    .start_in (erase_start),
    .busy_out (timer_busy),
    .done_out (timer_done)
  );

  assign lnk.erase_ack_tgl = erase_ack_tgl;
  assign lnk.erase_armed   = erase_armed;

  // Toggle and level synchronisers; edges taken past the second stage
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tgl_s1  <= 1'b0;
      tgl_s2  <= 1'b0;
      tgl_s3  <= 1'b0;
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      req_s3  <= 1'b0;
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      tgl_s1  <= lnk.instr_tgl;
      tgl_s2  <= tgl_s1;
      tgl_s3  <= tgl_s2;
      req_s1  <= lnk.erase_req_tgl;
      req_s2  <= req_s1;
      req_s3  <= req_s2;
      hold_s1 <= lnk.row_hold;
      hold_s2 <= hold_s1;
    end
  end

  // Word is stable long before its toggle arrives through two stages
  assign instr_new   = tgl_s2 ^ tgl_s3;
  assign erase_start = req_s2 ^ req_s3;
  assign cmd         = lnk.instr_word[3:0];
  assign op_lo       = lnk.instr_word[11:4];
  assign op_hi       = lnk.instr_word[19:12];
  assign is_tw = cmd == CMD_TW || cmd == CMD_TW_INC
              || cmd == CMD_TW_PROG;
  assign table_address_pointer = {pointer_upper_byte, pointer_high_byte,
                                  pointer_low_byte};

  // Working register loaded by the literal-move core instruction
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wreg <= 8'h00;
    end else if (instr_new && cmd == CMD_CORE && op_hi == OP_MOVLW) begin
      wreg <= op_lo;
    end
  end

  // Pointer bytes: core moves and clears, post-increment on write-increment
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pointer_upper_byte <= 6'h00;
      pointer_high_byte  <= 8'h00;
      pointer_low_byte   <= 8'h00;
    end else if (instr_new && cmd == CMD_CORE
                 && (op_hi == OP_MOVWF || op_hi == OP_CLRF)) begin
      if (op_lo == FILE_PTR_U) begin
        pointer_upper_byte <= (op_hi == OP_MOVWF) ? wreg[5:0] : 6'h00;
      end else if (op_lo == FILE_PTR_H) begin
        pointer_high_byte <= (op_hi == OP_MOVWF) ? wreg : 8'h00;
      end else if (op_lo == FILE_PTR_L) begin
        pointer_low_byte <= (op_hi == OP_MOVWF) ? wreg : 8'h00;
      end
    end else if (instr_new && cmd == CMD_TW_INC) begin
      {pointer_upper_byte, pointer_high_byte, pointer_low_byte} <=
        table_address_pointer + PTR_STEP;
    end
  end

  // Memory control bits set and cleared by bit instructions
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      memory_control_reg <= MEMCTL_RESET;
    end else if (instr_new && cmd == CMD_CORE && op_lo == FILE_MEMCTL) begin
      if (op_hi[7:4] == OP_BSF_NIB) begin
        memory_control_reg[op_hi[3:1]] <= 1'b1;
      end else if (op_hi[7:4] == OP_BCF_NIB) begin
        memory_control_reg[op_hi[3:1]] <= 1'b0;
      end
    end
  end

  // Programming control: written only with config space selected
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      panel_write_control <= PANEL_RESET;
    end else if (instr_new && is_tw && !erase_busy_out
                 && table_address_pointer == PANEL_CTRL_ADDR
                 && memory_control_reg[CFG_SEL_BIT]) begin
      panel_write_control <= op_lo;
    end
  end

  // Option write arms the erase; the next instruction disarms it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      erase_option_control <= 8'h00;
      erase_armed          <= 1'b0;
    end else if (instr_new && is_tw
                 && table_address_pointer == ERASE_CTRL_ADDR) begin
      if (option_mask(op_lo) != 6'h00) begin
        erase_option_control <= op_lo;
        erase_armed          <= 1'b1;
      end else begin
        erase_armed <= 1'b0;
      end
    end else if (instr_new) begin
      erase_armed <= 1'b0;
    end
  end

  // Row erase mode latched when the start-programming write arrives
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      row_mode <= 1'b0;
    end else if (instr_new && cmd == CMD_TW_PROG) begin
      row_mode <= memory_control_reg[ROW_FREE_BIT]
               && memory_control_reg[WEN_BIT]
               && memory_control_reg[PGM_SEL_BIT]
               && !memory_control_reg[CFG_SEL_BIT]
               && panel_write_control == PANEL_MULTI_ROW;
    end else if (instr_new) begin
      row_mode <= 1'b0;
    end
  end

  // Bulk erase: targets held while the timer runs, ack on completion
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      erase_target  <= 6'h00;
      erase_ack_tgl <= 1'b0;
    end else if (erase_start) begin
      erase_target <= option_mask(erase_option_control);
    end else if (timer_done) begin
      erase_target  <= 6'h00;
      erase_ack_tgl <= req_s3;
    end
  end

  // Protection only falls on erase completion; a set in that cycle wins
  // Other configuration bits live elsewhere and are never touched here
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      code_protect <= PROTECT_RESET;
    end else begin
      code_protect <= (code_protect & ~(timer_done ? erase_target : 6'h00))
                    | protect_set_in;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      serial_prog_data_out      <= 1'b0;
      serial_prog_data_oe_out   <= 1'b0;
      erase_busy_out            <= 1'b0;
      erase_target_out          <= 6'h00;
      code_protect_out          <= PROTECT_RESET;
      row_erase_active_out      <= 1'b0;
      row_offset_out            <= 7'h00;
      panel_write_control_out   <= PANEL_RESET;
      memory_control_reg_out    <= MEMCTL_RESET;
      table_address_pointer_out <= 22'h000000;
    end else begin
      // Read-back of output data is not part of erase sequencing
      serial_prog_data_out      <= 1'b0;
      serial_prog_data_oe_out   <= 1'b0;
      erase_busy_out            <= timer_busy || erase_start;
      erase_target_out          <= erase_target;
      code_protect_out          <= code_protect;
      row_erase_active_out      <= hold_s2 && row_mode;
      row_offset_out <= table_address_pointer[PANEL_LSB-1:ROW_LSB];
      panel_write_control_out   <= panel_write_control;
      memory_control_reg_out    <= memory_control_reg;
      table_address_pointer_out <= table_address_pointer;
    end
  end

  a_option_valid: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(erase_armed) |-> option_mask(erase_option_control) != 6'h00
      && $past(table_address_pointer) == ERASE_CTRL_ADDR)
    else $error("erase armed by an undefined option or address");

  a_chip_mask: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    erase_start && erase_option_control == OPT_CHIP
      |=> ##1 erase_target_out == MASK_ALL)
    else $error("chip erase does not target every block");

  a_protect_only_erase: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (|($past(code_protect) & ~code_protect)) |-> $past(timer_done))
    else $error("protection cleared without a bulk erase");

  a_protect_cleared: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    timer_done |=> (code_protect & $past(erase_target)
      & ~$past(protect_set_in)) == 6'h00)
    else $error("erased block keeps its protection");

  a_pointer_step: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    instr_new && cmd == CMD_TW_INC
      |=> table_address_pointer == $past(table_address_pointer) + PTR_STEP)
    else $error("post-increment write did not step pointer by 2");

  a_panel_write: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    instr_new && is_tw && !erase_busy_out && memory_control_reg[CFG_SEL_BIT]
      && table_address_pointer == PANEL_CTRL_ADDR
      |=> ##1 panel_write_control_out == $past(op_lo, 2))
    else $error("programming control write lost");

  a_row_needs_mode: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    row_erase_active_out |-> $past(row_mode) && $past(hold_s2))
    else $error("row erase active without enable and hold");

  a_busy_covers: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    erase_start |=> erase_busy_out [*3])
    else $error("busy not shown right after erase start");

endmodule : sesq_top

// >>> core/sesq_pkg.sv
// Shared constants for the serial erase sequencer: serial framing,
// command codes, location addresses, erase option codes and timing.
// Assumes a 25 MHz system clock and a programmer-driven serial clock.
package sesq_pkg;

  // Serial instruction framing
  localparam int INSTR_BITS   = 20;
  localparam int CMD_BITS     = 4;
  localparam int OPERAND_BITS = 16;
  localparam int ADDR_BITS    = 22;
  localparam logic [4:0] LAST_BIT_IDX     = 5'h13;
  localparam logic [4:0] ROW_HOLD_SET_IDX = 5'h02;
  localparam logic [4:0] ERASE_START_IDX  = 5'h03;

  // Four-bit serial commands
  localparam logic [3:0] CMD_CORE    = 4'h0;
  localparam logic [3:0] CMD_TW      = 4'hC;
  localparam logic [3:0] CMD_TW_INC  = 4'hD;
  localparam logic [3:0] CMD_TW_PROG = 4'hF;

  // Core instruction opcodes and file addresses understood here
  localparam logic [7:0] OP_MOVLW    = 8'h0E;
  localparam logic [7:0] OP_MOVWF    = 8'h6E;
  localparam logic [7:0] OP_CLRF     = 8'h6A;
  localparam logic [3:0] OP_BSF_NIB  = 4'h8;
  localparam logic [3:0] OP_BCF_NIB  = 4'h9;
  localparam logic [7:0] FILE_PTR_U  = 8'hF8;
  localparam logic [7:0] FILE_PTR_H  = 8'hF7;
  localparam logic [7:0] FILE_PTR_L  = 8'hF6;
  localparam logic [7:0] FILE_MEMCTL = 8'hA6;

  // Memory control register bits and reset
  localparam int PGM_SEL_BIT  = 7;
  localparam int CFG_SEL_BIT  = 6;
  localparam int ROW_FREE_BIT = 4;
  localparam int WEN_BIT      = 3;
  localparam logic [7:0] MEMCTL_RESET = 8'h00;

  // Erase and programming control locations
  localparam logic [21:0] ERASE_CTRL_ADDR = 22'h3C0004;
  localparam logic [21:0] PANEL_CTRL_ADDR = 22'h3C0006;
  localparam logic [21:0] PTR_STEP        = 22'h000002;
  localparam logic [7:0]  PANEL_RESET     = 8'h00;
  localparam logic [7:0]  PANEL_MULTI_ROW = 8'h40;

  // Erase option codes
  localparam logic [7:0] OPT_CHIP      = 8'h80;
  localparam logic [7:0] OPT_EEPROM    = 8'h81;
  localparam logic [7:0] OPT_BOOT      = 8'h83;
  localparam logic [7:0] OPT_BLK_FIRST = 8'h88;
  localparam logic [7:0] OPT_BLK_LAST  = 8'h8B;

  // Erase target / protection mask layout
  localparam int MASK_W      = 6;
  localparam int MASK_BOOT   = 0;
  localparam int MASK_BLK0   = 1;
  localparam int MASK_EEPROM = 5;
  localparam logic [5:0] MASK_ALL      = 6'h3F;
  localparam logic [5:0] PROTECT_RESET = 6'h00;

  // Row and panel geometry: 64-byte rows inside 8-Kbyte panels
  localparam int ROW_LSB   = 6;
  localparam int PANEL_LSB = 13;

  // Self-timed bulk erase time, rounded up to whole clocks
  localparam int SYS_CLK_PERIOD_NS   = 40;
  localparam int ERASE_TIME_NS       = 5000000;
  localparam int ERASE_CYCLES_DFLT   =
    (ERASE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Erase option code to target mask; zero means not an option
  function automatic logic [5:0] option_mask(input logic [7:0] opt);
    logic [5:0] m;
    m = 6'h00;
    if (opt == OPT_CHIP) begin
      m = MASK_ALL;
    end else if (opt == OPT_EEPROM) begin
      m[MASK_EEPROM] = 1'b1;
    end else if (opt == OPT_BOOT) begin
      m[MASK_BOOT] = 1'b1;
    end else if (opt >= OPT_BLK_FIRST && opt <= OPT_BLK_LAST) begin
      m[MASK_BLK0 + int'(opt[1:0])] = 1'b1;
    end
    return m;
  endfunction : option_mask

endpackage : sesq_pkg

// >>> core/sesq_link_if.sv
// Carrier between the serial-clock logic and the system-clock core.
// Every signal has one driver; the core resynchronises the toggles and hold, not the word.
`timescale 1ns/1ps
interface sesq_link_if;
  logic [19:0] instr_word;
  logic        instr_tgl;
  logic        erase_req_tgl;
  logic        erase_ack_tgl;
  logic        erase_armed;
  logic        row_hold;

  modport link (output instr_word, output instr_tgl,
                output erase_req_tgl, output row_hold,
                input erase_ack_tgl, input erase_armed);
  modport core (input instr_word, input instr_tgl,
                input erase_req_tgl, input row_hold,
                output erase_ack_tgl, output erase_armed);
endinterface : sesq_link_if

// >>> core/sesq_serial_link.sv
// Serial-clock side: shifts instructions in on falling edges, marks
// the bulk erase start and the row erase hold window.
// Assumes the serial clock only runs while the programmer is active.
`timescale 1ns/1ps
module sesq_serial_link
  import sesq_pkg::*;
(
  // Link clock and reset
  input  wire logic link_clk_in,
  input  wire logic rst_in,
  // Serial data, already on the link clock
  input  wire logic data_in,
  // Crossing to the core
  sesq_link_if.link lnk
);
  import sesq_pkg::*;

  logic        rst_s1, rst_s2, ack_s1, ack_s2, arm_s1, arm_s2;
  logic [4:0]  bit_cnt;
  logic [19:0] shift;
  logic        row_arm;
  logic        bulk_pending;
  logic        link_busy;
  logic [19:0] next_word;

  // Two-stage synchronisers for the reset, ack and armed levels
  always_ff @(negedge link_clk_in) begin
    rst_s1 <= rst_in;
    rst_s2 <= rst_s1;
    ack_s1 <= lnk.erase_ack_tgl;
    ack_s2 <= ack_s1;
    arm_s1 <= lnk.erase_armed;
    arm_s2 <= arm_s1;
  end

  // Busy until the core answers the erase request toggle
  assign link_busy = lnk.erase_req_tgl != ack_s2;
  assign next_word = {data_in, shift[19:1]};

  // Bits latched on falling edges, first bit lands in bit 0
  always_ff @(negedge link_clk_in) begin
    if (rst_s2) begin
      bit_cnt <= 5'h00;
      shift   <= 20'h00000;
    end else if (link_busy) begin
      bit_cnt <= 5'h00;
    end else begin
      shift   <= next_word;
      bit_cnt <= (bit_cnt == LAST_BIT_IDX) ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // Completed instruction handed over with a toggle
  always_ff @(negedge link_clk_in) begin
    if (rst_s2) begin
      lnk.instr_word <= 20'h00000;
      lnk.instr_tgl  <= 1'b0;
    end else if (!link_busy && bit_cnt == LAST_BIT_IDX) begin
      lnk.instr_word <= next_word;
      lnk.instr_tgl  <= ~lnk.instr_tgl;
    end
  end

  // Erase start and row hold marks, counted in serial clock edges
  always_ff @(negedge link_clk_in) begin
    if (rst_s2) begin
      row_arm           <= 1'b0;
      bulk_pending      <= 1'b0;
      lnk.row_hold      <= 1'b0;
      lnk.erase_req_tgl <= 1'b0;
    end else if (!link_busy) begin
      if (bit_cnt == LAST_BIT_IDX) begin
        row_arm      <= next_word[3:0] == CMD_TW_PROG;
        bulk_pending <= arm_s2 && next_word[3:0] == CMD_CORE;
      end else if (bit_cnt == ROW_HOLD_SET_IDX && row_arm) begin
        row_arm      <= 1'b0;
      end
      if (bit_cnt == ERASE_START_IDX && bulk_pending) begin
        lnk.erase_req_tgl <= ~lnk.erase_req_tgl;
        bulk_pending      <= 1'b0;
      end
      // Held high across the 4th pulse, ended by its falling edge
      if (bit_cnt == ROW_HOLD_SET_IDX && row_arm) begin
        lnk.row_hold <= 1'b1;
      end else if (bit_cnt == ERASE_START_IDX) begin
        lnk.row_hold <= 1'b0;
      end
    end
  end

  a_busy_no_shift: assert property (
    @(negedge link_clk_in) disable iff (rst_s2)
    link_busy |=> bit_cnt == 5'h00 && $stable(lnk.instr_tgl))
    else $error("serial bits taken during bulk erase");

  a_erase_start_edge: assert property (
    @(negedge link_clk_in) disable iff (rst_s2)
    $changed(lnk.erase_req_tgl) |-> $past(bit_cnt) == ERASE_START_IDX)
    else $error("bulk erase started off the 4th falling edge");

  a_row_hold_len: assert property (
    @(negedge link_clk_in) disable iff (rst_s2)
    $rose(lnk.row_hold) |=> !lnk.row_hold && bit_cnt == 5'h04)
    else $error("row hold window not ended by 4th falling edge");

endmodule : sesq_serial_link

// >>> core/sesq_erase_timer.sv
// Self-timed bulk erase counter on the system clock.
// Assumes start is a single-cycle pulse; starts while busy are dropped.
`timescale 1ns/1ps
module sesq_erase_timer #(
  parameter int CYCLES = 125000
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] helper_len;

  // Busy for exactly CYCLES clocks, then a done pulse
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt      <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        cnt      <= CW'(CYCLES - 1);
      end else if (busy_out) begin
        if (cnt == '0) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt <= cnt - CW'(1);
        end
      end
    end
  end

  // Helper count of busy cycles for the length check
  always_ff @(posedge clk_in) begin
    if (rst_in || !busy_out) begin
      helper_len <= '0;
    end else begin
      helper_len <= helper_len + CW'(1);
    end
  end

  a_erase_length: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(busy_out) |-> done_out && $past(helper_len) == CW'(CYCLES - 1))
    else $error("bulk erase time differs from the set count");

endmodule : sesq_erase_timer

// >>> tb/sesq_prog_model.sv
// Programmer model: drives the serial clock and data of the port.
// Assumes the device takes bits on falling clock edges.
`timescale 1ns/1ps
module sesq_prog_model (
  // Serial link towards the device
  output logic clk_out,
  output logic data_out
);
  // Clock stands low between frames
  initial begin
    clk_out  = 1'b0;
    data_out = 1'b0;
  end
  // One bit a pulse, data set on the rise, held until the fall
  task automatic bit_out(input logic b, input int hi_ns);
    clk_out  = 1'b1;
    data_out = b;
    #(hi_ns);
    clk_out = 1'b0;
    #80;
  endtask : bit_out
  // Data held low, as an erase in progress needs
  task automatic pulses(input int n);
    repeat (n) bit_out(1'b0, 80);
  endtask : pulses
  // Command then operand, bit 0 first
  task automatic send(input logic [3:0] c, input logic [15:0] p);
    logic [19:0] w;
    w = {p, c};
    for (int i = 0; i < 20; i++) bit_out(w[i], 80);
    data_out = ~w[19]; // Released line keeps no stale level
  endtask : send
  // Pointer load by core moves, upper byte first
  task automatic load_ptr(input logic [21:0] a);
    send(4'h0, {8'h0E, 2'b00, a[21:16]});
    send(4'h0, 16'h6EF8);
    send(4'h0, {8'h0E, a[15:8]});
    send(4'h0, 16'h6EF7);
    send(4'h0, {8'h0E, a[7:0]});
    send(4'h0, 16'h6EF6);
  endtask : load_ptr
endmodule : sesq_prog_model

// >>> tb/serial_erase_sequencer_tb_top.sv
// Testbench: programmer model on the serial port, erase flows checked.
// Assumes the erase time is shortened to 20 system clocks.
`timescale 1ns/1ps
module serial_erase_sequencer_tb_top;
  logic        sys_clk_in;
  logic        rst_in;
  logic [5:0]  protect_set_in;
  logic        sclk, sdat, busy, act, dout, doe;
  logic [5:0]  tgt, prot;
  logic [6:0]  row;
  logic [7:0]  panel, memctl;
  logic [21:0] ptr;
  int          fails   = 0;
  int          checked = 0;
  int          cycles  = 0;
  // Option codes and the targets each must hit; 82h is undefined
  logic [7:0]  opts [8] = '{8'h80, 8'h81, 8'h83, 8'h88, 8'h89, 8'h8A,
                            8'h8B, 8'h82};
  logic [5:0]  masks [8] = '{6'h3F, 6'h20, 6'h01, 6'h02, 6'h04, 6'h08,
                             6'h10, 6'h00};

  // Partner and design
  sesq_prog_model i_prog (.clk_out(sclk), .data_out(sdat));
  sesq_top #(.ERASE_CYCLES(20)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .serial_clk_in(sclk),
    .serial_prog_data_in(sdat), .serial_prog_data_out(dout),
    .serial_prog_data_oe_out(doe), .protect_set_in(protect_set_in),
    .erase_busy_out(busy), .erase_target_out(tgt),
    .code_protect_out(prot), .row_erase_active_out(act),
    .row_offset_out(row), .panel_write_control_out(panel),
    .memory_control_reg_out(memctl), .table_address_pointer_out(ptr));

  // 25 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // Hang guard, well above the expected run length
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict;
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Lets the crossing and output registers settle
  task automatic wclk(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : wclk
  // Bulk erase with all protection set first
  task automatic run_erase(input logic [7:0] opt, input logic [5:0] m);
    int n;
    @(posedge sys_clk_in) protect_set_in <= 6'h3F;
    @(posedge sys_clk_in) protect_set_in <= 6'h00;
    i_prog.load_ptr(22'h3C0004);
    wclk(6);
    check(ptr, 22'h3C0004);
    i_prog.send(4'hC, {8'h00, opt});
    i_prog.send(4'h0, 16'h0000);
    i_prog.pulses(4);
    wclk(8);
    check(busy, m != 6'h00);
    check(tgt, m);
    // Falls during the erase must be dropped; the timer is still running
    if (m != 6'h00) begin
      i_prog.pulses(2);
      check(busy, 1'b1);
    end
    // Clock stands still until done, so the ack needs exactly two falls
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      wclk(1);
      n++;
    end
    i_prog.pulses(m != 6'h00 ? 2 : 16);
    wclk(6);
    check(prot, {~m});
    check(busy, 1'b0);
  endtask : run_erase

  initial begin
    rst_in         = 1'b1;
    protect_set_in = 6'h00;
    fork
      wclk(16);
      i_prog.pulses(4);
    join
    @(posedge sys_clk_in) rst_in <= 1'b0;
    // Two falls clear the link's reset sync; a third would shift a bit
    i_prog.pulses(2);
    wclk(4);
    check(ptr | memctl | panel | tgt | prot | row
          | {doe, dout, act, busy}, 22'h0);
    // Row erase walk: enable bits, 40h to the control location
    i_prog.send(4'h0, 16'h8EA6);
    i_prog.send(4'h0, 16'h8CA6);
    i_prog.send(4'h0, 16'h86A6);
    i_prog.load_ptr(22'h3C0006);
    i_prog.send(4'hC, 16'h0040);
    wclk(6);
    check({memctl, panel}, 16'hC840);
    i_prog.send(4'h0, 16'h8EA6);
    i_prog.send(4'h0, 16'h9CA6);
    i_prog.send(4'h0, 16'h88A6);
    i_prog.send(4'h0, 16'h6AF8);
    i_prog.send(4'h0, 16'h6AF7);
    i_prog.send(4'h0, 16'h6AF6);
    wclk(6);
    check({memctl, ptr}, {8'h98, 22'h000000});
    i_prog.send(4'hF, 16'h5A5A);
    i_prog.pulses(3);
    fork
      i_prog.bit_out(1'b0, 2000);
      begin
        wclk(25);
        check({act, row}, 8'h80);
      end
    join
    wclk(6);
    check(act, 1'b0);
    i_prog.pulses(16);
    for (int i = 0; i < 8; i++) run_erase(opts[i], masks[i]);
    check(panel, 8'h40);
    i_prog.load_ptr(22'h001FD0);
    i_prog.send(4'hD, 16'h1234);
    wclk(6);
    check({row, ptr}, {7'h7F, 22'h001FD2});
    give_verdict();
  end
endmodule : serial_erase_sequencer_tb_top
